// ### rtl/cmp_skip_decode.sv
`timescale 1ns/100ps
module cmp_skip_decode
    import cmp_skip_pkg::*;
(
    cmp_skip_if.decoder dif
);
    logic [6:0] opc;
    logic       acc_bit;
    logic [7:0] faddr;

    assign opc     = dif.instr[OPC_MSB:OPC_LSB];
    assign acc_bit = dif.instr[ACCESS_BIT];
    assign faddr   = dif.instr[7:0];

    always_comb begin
        case (opc)
            OPC_SKIP_GT: dif.kind = CMP_GT; // [RULE1]
            OPC_SKIP_LT: dif.kind = CMP_LT; // [RULE2]
            default:     dif.kind = CMP_NONE;
        endcase
    end

    always_comb begin
        if (acc_bit) begin
            dif.addr = {dif.bank[3:0], faddr}; // [RULE5]
        end else if (dif.ext_en && faddr <= INDEX_LIMIT) begin
            dif.addr = ADDR_W'(dif.index_base + {4'h0, faddr}); // [RULE6]
        end else if (faddr >= ACCESS_SPLIT) begin
            dif.addr = {ACCESS_HI_BANK, faddr}; // [RULE5]
        end else begin
            dif.addr = {BANK_RESET, faddr}; // [RULE5]
        end
    end
endmodule

// ### rtl/cmp_skip_if.sv
`timescale 1ns/100ps
interface cmp_skip_if;
    import cmp_skip_pkg::*;
    logic [cmp_skip_pkg::WORD_W-1:0] instr;
    logic [7:0]                      bank;
    logic [cmp_skip_pkg::ADDR_W-1:0] index_base;
    logic                            ext_en;
    cmp_kind_t                       kind;
    logic [cmp_skip_pkg::ADDR_W-1:0] addr;

    modport decoder (input instr, bank, index_base, ext_en, output kind, addr);
    modport core    (output instr, bank, index_base, ext_en, input kind, addr);
endinterface

// ### rtl/cmp_skip_pkg.sv
package cmp_skip_pkg;
    localparam logic [6:0] OPC_SKIP_GT  = 7'h32; // 0110 010
    localparam logic [6:0] OPC_SKIP_LT  = 7'h30; // 0110 000
    localparam int         OPC_MSB      = 15;
    localparam int         OPC_LSB      = 9;
    localparam int         ACCESS_BIT   = 8;
    localparam logic [7:0] INDEX_LIMIT  = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] BANK_RESET   = 4'h0;
    localparam logic [7:0] WORK_REG_RESET = 8'h00;
    localparam int         ADDR_W       = 12;
    localparam int         DATA_W       = 8;
    localparam int         WORD_W       = 16;

    typedef enum logic [1:0] {
        CMP_NONE,
        CMP_GT,
        CMP_LT
    } cmp_kind_t;
endpackage

// ### rtl/compare_skip_instructions.sv
// Functional notes
// RULE1 - Decode greater-than skip from top bits 0110 010, access bit, 8-bit address.
// RULE2 - Decode less-than skip from top bits 0110 000, access bit, 8-bit address.
// RULE3 - Greater-than: if byte exceeds working register unsigned, discard next, execute nop.
// RULE4 - Less-than: if byte below working register unsigned, discard next, execute nop.
// RULE5 - Access bit clear selects access bank; set uses bank select register.
// RULE6 - Access clear, extended set on, address up to 95: indexed literal offset.
// RULE7 - One cycle no skip, two on skip, three if discarded word is two-word.
// RULE8 - No skip lets next execute; operand, working register, flags stay unchanged.
`timescale 1ns/100ps
module compare_skip_instructions
    import cmp_skip_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Instruction issue
    input  wire logic              instr_valid,
    input  wire logic [WORD_W-1:0] instr,
    input  wire logic              next_is_two_word,
    // Core state
    input  wire logic [DATA_W-1:0] working_register,
    input  wire logic [7:0]        bank_select_register,
    input  wire logic [ADDR_W-1:0] index_base,
    input  wire logic              ext_set_en,
    // Data memory read
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_rd,
    input  wire logic [DATA_W-1:0] mem_rdata,
    // Pipeline control
    output logic                   busy,
    output logic                   flush_next,
    output logic                   done,
    output logic                   skip_taken,
    output logic [1:0]             cycles_used
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EVAL,
        ST_NOP1,
        ST_NOP2
    } state_t;

    state_t             state_q;
    cmp_kind_t          kind_q;
    logic               two_word_q;
    logic [DATA_W-1:0]  w_q;
    logic               skip;
    cmp_kind_t          kind_now;
    logic [ADDR_W-1:0]  addr_now;

    cmp_skip_if dif();
    assign dif.instr      = instr;
    assign dif.bank       = bank_select_register;
    assign dif.index_base = index_base;
    assign dif.ext_en     = ext_set_en;
    assign kind_now       = dif.kind;
    assign addr_now       = dif.addr;

    cmp_skip_decode u_dec (
        .dif (dif)
    );

    function automatic logic cond_met(cmp_kind_t k, logic [DATA_W-1:0] f,
                                      logic [DATA_W-1:0] w);
        logic [DATA_W:0] diff;
        diff = {1'b0, f} - {1'b0, w};
        case (k)
            CMP_GT:  cond_met = !diff[DATA_W] && (diff != '0); // [RULE3]
            CMP_LT:  cond_met = diff[DATA_W];                  // [RULE4]
            default: cond_met = 1'b0;
        endcase
    endfunction

    // Snapshot; compare only reads, never writes back
    always_ff @(posedge clk) begin
        if (rst) begin
            kind_q     <= CMP_NONE;
            two_word_q <= 1'b0;
            w_q        <= WORK_REG_RESET;
            mem_addr   <= '0;
        end else if (state_q == ST_IDLE && instr_valid) begin
            kind_q     <= kind_now;
            two_word_q <= next_is_two_word;
            w_q        <= working_register; // [RULE8]
            mem_addr   <= addr_now;          // [RULE5] [RULE6]
        end
    end

    assign skip = cond_met(kind_q, mem_rdata, w_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (instr_valid && kind_now != CMP_NONE) state_q <= ST_EVAL;
                ST_EVAL: state_q <= skip ? ST_NOP1 : ST_IDLE;          // [RULE7] [RULE8]
                ST_NOP1: state_q <= two_word_q ? ST_NOP2 : ST_IDLE;    // [RULE7]
                ST_NOP2: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done        <= 1'b0;
            skip_taken  <= 1'b0;
            cycles_used <= 2'd0;
            flush_next  <= 1'b0;
        end else begin
            done       <= 1'b0;
            flush_next <= 1'b0;
            case (state_q)
                ST_EVAL: begin
                    flush_next <= skip;                              // [RULE3] [RULE4]
                    skip_taken <= skip;
                    if (!skip) begin
                        done        <= 1'b1;
                        cycles_used <= 2'd1;                         // [RULE7]
                    end
                end
                ST_NOP1: if (!two_word_q) begin
                    done        <= 1'b1;
                    cycles_used <= 2'd2;                             // [RULE7]
                end
                ST_NOP2: begin
                    done        <= 1'b1;
                    cycles_used <= 2'd3;                             // [RULE7]
                end
                default: ;
            endcase
        end
    end

    assign mem_rd = (state_q == ST_EVAL);
    assign busy   = (state_q != ST_IDLE);
endmodule

// ### sim/cmp_skip_props.sv
`timescale 1ns/100ps
module cmp_skip_props
    import cmp_skip_pkg::*;
(
    input wire logic        clk, rst, instr_valid, next_is_two_word, ext_set_en,
    input wire logic        mem_rd, busy, flush_next, done, skip_taken,
    input wire logic [15:0] instr,
    input wire logic [7:0]  working_register, bank_select_register, mem_rdata,
    input wire logic [11:0] index_base, mem_addr,
    input wire logic [1:0]  cycles_used
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic        take, gt_q, tw_q, hit;
    logic [7:0]  w_q, f;
    logic [11:0] ea_q;
    assign f = instr[7:0];
    assign take = !busy && instr_valid && instr[15:9] inside {OPC_SKIP_GT, OPC_SKIP_LT};
    assign hit = gt_q ? mem_rdata > w_q : mem_rdata < w_q;
    always_ff @(posedge clk) begin
        if (take) begin
            gt_q <= instr[15:9] == OPC_SKIP_GT;
            tw_q <= next_is_two_word;
            w_q  <= working_register;
            ea_q <= instr[8] ? {bank_select_register[3:0], f}
                  : (ext_set_en && f <= INDEX_LIMIT) ? index_base + {4'h0, f}
                  : {(f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK, f};
        end
    end
    a_take_reads: assert property (take |=> mem_rd && busy)
        else $error("no read after take");
    a_other_ignored: assert property (!busy && instr_valid && !take |=> !busy)
        else $error("foreign opcode taken");
    a_addr_select: assert property (mem_rd |-> mem_addr == ea_q)
        else $error("operand address wrong");
    a_gt_skip: assert property (mem_rd && gt_q |=> flush_next == ($past(mem_rdata) > w_q))
        else $error("greater skip wrong");
    a_lt_skip: assert property (mem_rd && !gt_q |=> flush_next == ($past(mem_rdata) < w_q))
        else $error("less skip wrong");
    a_one_cycle: assert property (mem_rd && !hit |=> done && cycles_used == 2'd1)
        else $error("no skip timing wrong");
    a_two_cycle: assert property (flush_next && !tw_q |=> done && cycles_used == 2'd2)
        else $error("skip timing wrong");
    a_three_cycle: assert property (flush_next && tw_q |=> !done ##1 done && cycles_used == 2'd3)
        else $error("two word skip timing wrong");
endmodule
bind compare_skip_instructions cmp_skip_props u_props (.*);

// ### sim/compare_skip_instructions_tb.sv
`timescale 1ns/100ps
module compare_skip_instructions_tb;
    import cmp_skip_pkg::*;
    logic clk = 0, rst = 1, instr_valid = 0, next_is_two_word = 0, ext_set_en = 0;
    logic        mem_rd, busy, flush_next, done, skip_taken;
    logic [15:0] instr = '0;
    logic [7:0]  working_register = '0, bank_select_register = '0, mem_rdata;
    logic [11:0] index_base = '0, mem_addr;
    logic [1:0]  cycles_used;
    logic [31:0] seed = 32'd73636;
    int num_errors = 0, checks_done = 0, cyc = 0;
    always #12.5 clk = ~clk;
    compare_skip_instructions u_dut (.*);
    data_mem_model u_mem (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
        if (a) return {bank_select_register[3:0], f};
        if (ext_set_en && f <= 8'h5f) return index_base + {4'h0, f};
        return {(f < 8'h60) ? 4'h0 : 4'hf, f};
    endfunction
    function automatic logic [7:0] mem_val(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report;
        end
    end
    task automatic run_one(input logic [15:0] w, input logic [7:0] wv, input logic tw);
        logic [11:0] ea;
        logic        sk;
        int          n;
        ea = exp_addr(w[8], w[7:0]);
        sk = (w[15:9] == OPC_SKIP_GT) ? mem_val(ea) > wv : mem_val(ea) < wv;
        instr = w;
        working_register = wv;
        next_is_two_word = tw;
        instr_valid = 1;
        @(negedge clk);
        instr_valid = 0;
        if (w[15:9] != OPC_SKIP_GT && w[15:9] != OPC_SKIP_LT) begin
            repeat (3) begin
                chk(busy, 16'h0);
                @(negedge clk);
            end
            return;
        end
        chk(mem_addr, ea);
        n = 0;
        while (done !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0, done}, 16'h1);
        chk(16'(n), sk ? (tw ? 16'h3 : 16'h2) : 16'h1);
        chk({skip_taken, cycles_used}, {sk, sk ? (tw ? 2'd3 : 2'd2) : 2'd1});
    endtask
    initial begin
        logic [6:0] op;
        logic [7:0] f;
        repeat (8) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 200; i++) begin
            if (i == 100) begin
                rst = 1;
                repeat (2) @(negedge clk);
                chk({busy, done, flush_next, skip_taken, cycles_used}, 16'h0);
                chk(mem_addr, 16'h0);
                rst = 0;
            end
            seed = lfsr(seed);
            bank_select_register = seed[31:24];
            index_base = seed[23:12];
            ext_set_en = seed[11];
            op = (i % 5 == 4) ? seed[15:9] : (seed[10] ? OPC_SKIP_GT : OPC_SKIP_LT);
            f = (i % 3 == 0) ? 8'h5f + {7'h0, seed[0]} : seed[7:0];
            run_one({op, seed[8], f}, (i % 4 == 0) ? mem_val(exp_addr(seed[8], f))
                                                   : seed[23:16], seed[2]);
        end
        final_report;
    end
endmodule

// ### sim/data_mem_model.sv
`timescale 1ns/100ps
module data_mem_model (
    input  wire logic        mem_rd,
    input  wire logic [11:0] mem_addr,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] val;
    assign val = mem_addr[7:0] ^ {mem_addr[11:8], mem_addr[11:8]} ^ 8'h3c;
    // Idle bus shows the inverse, never a stale byte
    assign mem_rdata = mem_rd ? val : ~val;
endmodule
